// file: verilog/dlk_top.sv
// data link transmitter and receiver, far-end alarm channel and error mask
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/100ps
`include "dlk_cfg.svh"
// Contract
// [R1] alarm word is register bits 15 to 10
// [R2] alarm sent ten times, then irq
// [R3] bit 8 gates alarm receive irq
// [R4] error pattern xored into chosen field
// [R5] rx irq bit 15, read clears
// [R6] tx irq bit 14, write clears
// [R7] bits 13-11 last rx buffer slot
// [R8] bit 10 set on idle flag
// [R9] bit 9 bad fcs or unaligned flag
// [R10] bit 8 seven ones abort seen
// [R11] bit 7 gates rx irq pin
// [R12] bit 6 forces link to ones
// [R13] host gives last tx slot, bits 5-3
// [R14] bit 2 aborts frame, back to flags
// [R15] bit 1 appends fcs
// [R16] bit 0 starts frame, byte irqs
// [R17] low byte control, high byte status
// [R18] zero insertion and removal after five ones
// [R19] eight byte buffers, sent in order
module dlk_top #(
	parameter int BIT_DIV    = 8,
	parameter int FIFO_DEPTH = 2
) (
	input  logic              clk_in,
	input  logic              rst_in,
	input  logic [7:0]        addr_in,
	input  logic [15:0]       wr_data_in,
	input  logic              wr_in,
	input  logic              rd_in,
	output logic [15:0]       rd_data_out,
	input  logic              dl_rx_bit_in,
	output logic              dl_tx_bit_out,
	input  logic              alarm_rx_bit_in,
	output logic              alarm_tx_bit_out,
	input  dlk_pkg::dlk_byte_t err_field_in,
	output dlk_pkg::dlk_byte_t err_field_out,
	output logic              data_link_irq_pin_out
);
	localparam int DW = $bits(dlk_pkg::dlk_entry_t);
	localparam int FA = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CW = $clog2(BIT_DIV);

	// refuse a divider or buffer the logic cannot serve
	if (BIT_DIV < 2 || FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
		$error("dlk_top: BIT_DIV >= 2 and FIFO_DEPTH a power of two >= 2");

	// byte-wise fcs update, bits taken lsb first
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ `DLK_CRC_POLY) : (r >> 1);
		return r;
	endfunction

	// eight-byte window decode
	function automatic logic in_win(input logic [7:0] a, input logic [7:0] base);
		return a[7:3] == base[7:3];
	endfunction

	// bit rate enable
	logic [CW-1:0] div_reg;
	logic          bit_en_reg;
	wire           div_wrap = (div_reg == CW'(BIT_DIV - 1));
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			div_reg    <= '0;
			bit_en_reg <= 1'b0;
		end
		else
		begin
			div_reg    <= div_wrap ? '0 : div_reg + 1'b1;
			bit_en_reg <= div_wrap;
		end

	// register decode
	wire wr_alarm = wr_in && addr_in == `DLK_OFS_ALARM;
	wire wr_dlcs  = wr_in && addr_in == `DLK_OFS_DLCS;
	wire rd_dlcs  = rd_in && addr_in == `DLK_OFS_DLCS;
	wire rd_arx   = rd_in && addr_in == `DLK_OFS_ARX;
	wire wr_txbuf = wr_in && in_win(addr_in, `DLK_OFS_TXBUF);

	logic [15:0]        alarm_reg;
	dlk_pkg::dlk_ctrl_t ctrl_reg;
	logic               rx_irq_reg, tx_irq_reg, idle_reg, bad_reg, abort_reg;
	logic [2:0]         rx_ptr_reg;
	logic [5:0]         arx_data_reg;
	logic               arx_flag_reg, atx_done_reg;
	logic [7:0]         txbuf_mem [8];
	logic [7:0]         rxbuf_mem [8];

	// events from the engines
	logic ev_rx_byte, ev_rx_end, ev_flag, ev_bad, ev_abort;
	logic ev_tx_svc, ev_tx_fin, ev_atx_done, ev_arx;

	// read mux; unmapped offsets read zero
	logic [15:0] rd_mux;
	assign rd_mux =
		(addr_in == `DLK_OFS_ALARM) ? alarm_reg :
		(addr_in == `DLK_OFS_DLCS) ? {rx_irq_reg, tx_irq_reg, rx_ptr_reg, idle_reg, bad_reg,
			abort_reg, ctrl_reg} : // R17
		(addr_in == `DLK_OFS_ARX) ? {arx_flag_reg, atx_done_reg, 8'h00, arx_data_reg} :
		in_win(addr_in, `DLK_OFS_TXBUF) ? {8'h00, txbuf_mem[addr_in[2:0]]} :
		in_win(addr_in, `DLK_OFS_RXBUF) ? {8'h00, rxbuf_mem[addr_in[2:0]]} : 16'h0000;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
			rd_data_out <= 16'h0000;
		else
			rd_data_out <= rd_in ? rd_mux : 16'h0000;

	// control registers; hardware clears self-acting bits, a host write wins
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			alarm_reg <= `DLK_ALARM_RST;
			ctrl_reg  <= `DLK_CTRL_RST;
		end
		else
		begin
			if (wr_alarm)
				alarm_reg <= wr_data_in;
			else if (ev_atx_done)
				alarm_reg[`DLK_B_ATXEN] <= 1'b0; // R2
			if (wr_dlcs)
				ctrl_reg <= wr_data_in[7:0]; // R17 R13
			else if (ev_tx_fin)
			begin
				ctrl_reg.send  <= 1'b0;
				ctrl_reg.abort <= 1'b0;
			end
		end

	// sticky status: a setting event beats the clearing access
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			rx_irq_reg   <= 1'b0;
			tx_irq_reg   <= 1'b0;
			idle_reg     <= 1'b0;
			bad_reg      <= 1'b0;
			abort_reg    <= 1'b0;
			arx_flag_reg <= 1'b0;
			atx_done_reg <= 1'b0;
		end
		else
		begin
			rx_irq_reg   <= (ev_rx_byte | ev_rx_end | ev_abort) | (rx_irq_reg & ~rd_dlcs); // R5
			tx_irq_reg   <= ev_tx_svc | (tx_irq_reg & ~wr_dlcs); // R6 R16
			idle_reg     <= ev_flag | (idle_reg & ~rd_dlcs); // R8
			bad_reg      <= ev_bad | (bad_reg & ~rd_dlcs); // R9
			abort_reg    <= ev_abort | (abort_reg & ~rd_dlcs); // R10
			arx_flag_reg <= ev_arx | (arx_flag_reg & ~rd_arx);
			atx_done_reg <= ev_atx_done | (atx_done_reg & ~rd_arx); // R2
		end

	// host side of the transmit buffer
	always_ff @(posedge clk_in)
		if (wr_txbuf)
			txbuf_mem[addr_in[2:0]] <= wr_data_in[7:0]; // R19

	// interrupt pin and error mask output
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			data_link_irq_pin_out <= 1'b0;
			err_field_out         <= '0;
		end
		else
		begin
			data_link_irq_pin_out <= (rx_irq_reg & ctrl_reg.rx_irq_en) | tx_irq_reg // R11
				| atx_done_reg | (arx_flag_reg & alarm_reg[`DLK_B_ARXIEN]); // R2 R3
			err_field_out.valid   <= err_field_in.valid;
			err_field_out.data    <= err_field_in.data ^ alarm_reg[7:0]; // R4
		end

	// transmit feeder: buffer bytes, fcs and abort into the two-entry queue
	dlk_pkg::dlk_txs_t  txs_reg, txs_next;
	logic [2:0]         idx_reg;
	logic [15:0]        tcrc_reg;
	logic               push_v, fifo_rdy, fifo_vld, fifo_pop, flush;
	dlk_pkg::dlk_entry_t push_e, head_e;
	wire                push_ok  = push_v && fifo_rdy;
	wire                last_idx = idx_reg == ctrl_reg.last_ptr; // R13 R19
	assign flush = ctrl_reg.abort && txs_reg != dlk_pkg::DLK_TX_ABORT; // R14

	always_comb
	begin
		push_v   = 1'b1;
		push_e   = '{raw: 1'b0, data: txbuf_mem[idx_reg]};
		txs_next = txs_reg;
		unique case (txs_reg)
			dlk_pkg::DLK_TX_IDLE:
			begin
				push_v = 1'b0;
				if (ctrl_reg.send)
					txs_next = dlk_pkg::DLK_TX_DATA; // R16
			end
			dlk_pkg::DLK_TX_DATA:
				if (push_ok && last_idx)
					txs_next = ctrl_reg.send_fcs ? dlk_pkg::DLK_TX_FCS_LO
						: dlk_pkg::DLK_TX_IDLE; // R15
			dlk_pkg::DLK_TX_FCS_LO:
			begin
				push_e.data = ~tcrc_reg[7:0];
				if (push_ok)
					txs_next = dlk_pkg::DLK_TX_FCS_HI;
			end
			dlk_pkg::DLK_TX_FCS_HI:
			begin
				push_e.data = ~tcrc_reg[15:8];
				if (push_ok)
					txs_next = dlk_pkg::DLK_TX_IDLE;
			end
			dlk_pkg::DLK_TX_ABORT:
			begin
				push_e = '{raw: 1'b1, data: `DLK_ABORT_BYTE}; // R14
				if (push_ok)
					txs_next = dlk_pkg::DLK_TX_IDLE;
			end
		endcase
		if (flush)
		begin
			push_v   = 1'b0;
			txs_next = dlk_pkg::DLK_TX_ABORT; // R14
		end
	end

	assign ev_tx_svc = push_ok && txs_reg == dlk_pkg::DLK_TX_DATA; // R16
	assign ev_tx_fin = push_ok && txs_next == dlk_pkg::DLK_TX_IDLE;

	// feeder state
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			txs_reg  <= dlk_pkg::DLK_TX_IDLE;
			idx_reg  <= 3'h0;
			tcrc_reg <= `DLK_CRC_INIT;
		end
		else
		begin
			txs_reg <= txs_next;
			if (txs_reg == dlk_pkg::DLK_TX_IDLE)
			begin
				idx_reg  <= 3'h0;
				tcrc_reg <= `DLK_CRC_INIT;
			end
			else if (ev_tx_svc)
			begin
				idx_reg  <= idx_reg + 3'h1; // R19
				tcrc_reg <= crc_byte(tcrc_reg, push_e.data); // R15
			end
		end

	// two-entry queue between feeder and serialiser; a full queue stalls the feeder
	logic [DW-1:0] q_mem [FIFO_DEPTH];
	logic [FA-1:0] q_wp_reg, q_rp_reg;
	logic [FA:0]   q_cnt_reg;
	assign fifo_rdy = q_cnt_reg != (FA+1)'(FIFO_DEPTH);
	assign fifo_vld = q_cnt_reg != '0;
	assign head_e   = q_mem[q_rp_reg];
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			q_wp_reg  <= '0;
			q_rp_reg  <= '0;
			q_cnt_reg <= '0;
		end
		else if (flush)
		begin
			q_wp_reg  <= '0;
			q_rp_reg  <= '0;
			q_cnt_reg <= '0;
		end
		else
		begin
			q_wp_reg  <= q_wp_reg + FA'(push_ok);
			q_rp_reg  <= q_rp_reg + FA'(fifo_pop);
			q_cnt_reg <= q_cnt_reg + (FA+1)'(push_ok) - (FA+1)'(fifo_pop);
		end
	always_ff @(posedge clk_in)
		if (push_ok)
			q_mem[q_wp_reg] <= push_e;

	// serialiser: lsb first, zero after five data ones, flags when queue is empty
	logic [6:0] sh_reg;
	logic [2:0] left_reg, tones_reg;
	logic       raw_reg;
	wire        stuff_now = tones_reg == `DLK_STUFF_RUN; // R18
	wire        load      = left_reg == 3'h0 && !stuff_now;
	dlk_pkg::dlk_entry_t ld_e;
	assign ld_e     = fifo_vld ? head_e : dlk_pkg::dlk_entry_t'{raw: 1'b1, data: `DLK_FLAG};
	assign fifo_pop = bit_en_reg && load && fifo_vld && !flush;
	wire        out_raw = load ? ld_e.raw : raw_reg;
	wire        out_bit = stuff_now ? 1'b0 : load ? ld_e.data[0] : sh_reg[0];
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			sh_reg        <= 7'h00;
			left_reg      <= 3'h0;
			tones_reg     <= 3'h0;
			raw_reg       <= 1'b1;
			dl_tx_bit_out <= 1'b1;
		end
		else if (bit_en_reg)
		begin
			dl_tx_bit_out <= ctrl_reg.dis_tx | out_bit; // R12
			tones_reg     <= (out_raw || !out_bit) ? 3'h0 : tones_reg + 3'h1; // R18
			if (load)
			begin
				sh_reg   <= ld_e.data[7:1];
				left_reg <= 3'h7;
				raw_reg  <= ld_e.raw;
			end
			else if (!stuff_now)
			begin
				sh_reg   <= sh_reg >> 1;
				left_reg <= left_reg - 3'h1;
			end
		end

	// receiver: flag, abort and stuffed-zero detection, byte assembly and fcs check
	logic [2:0]  rones_reg, bcnt_reg, wptr_reg;
	logic [6:0]  asm_reg;
	logic [15:0] rcrc_reg;
	logic        inframe_reg, gotbyte_reg;
	wire         rb      = dl_rx_bit_in;
	wire         is_flag = !rb && rones_reg == `DLK_FLAG_RUN;
	wire         is_stuf = !rb && rones_reg == `DLK_STUFF_RUN; // R18
	wire         data_b  = bit_en_reg && inframe_reg && !is_flag && !is_stuf;
	wire [7:0]   rx_byte = {rb, asm_reg};
	assign ev_flag    = bit_en_reg && is_flag; // R8
	assign ev_abort   = bit_en_reg && rb && rones_reg == `DLK_FLAG_RUN; // R10
	assign ev_rx_byte = data_b && bcnt_reg == 3'h7;
	assign ev_rx_end  = ev_flag && inframe_reg && (gotbyte_reg || bcnt_reg != 3'h7);
	assign ev_bad     = ev_rx_end && (bcnt_reg != 3'h7 || rcrc_reg != `DLK_CRC_GOOD); // R9
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			rones_reg   <= 3'h0;
			bcnt_reg    <= 3'h0;
			wptr_reg    <= 3'h0;
			rx_ptr_reg  <= 3'h0;
			asm_reg     <= 7'h00;
			rcrc_reg    <= `DLK_CRC_INIT;
			inframe_reg <= 1'b0;
			gotbyte_reg <= 1'b0;
		end
		else if (bit_en_reg)
		begin
			rones_reg <= !rb ? 3'h0 : (rones_reg == `DLK_ONES_MAX) ? rones_reg
				: rones_reg + 3'h1;
			if (ev_abort)
				inframe_reg <= 1'b0; // R10
			if (is_flag)
			begin
				inframe_reg <= 1'b1;
				gotbyte_reg <= 1'b0;
				bcnt_reg    <= 3'h0;
				rcrc_reg    <= `DLK_CRC_INIT;
			end
			else if (data_b)
			begin
				asm_reg  <= rx_byte[7:1];
				bcnt_reg <= bcnt_reg + 3'h1;
				if (ev_rx_byte)
				begin
					rx_ptr_reg  <= wptr_reg; // R7
					wptr_reg    <= wptr_reg + 3'h1; // R19
					gotbyte_reg <= 1'b1;
					rcrc_reg    <= crc_byte(rcrc_reg, rx_byte);
				end
			end
		end
	always_ff @(posedge clk_in)
		if (ev_rx_byte)
			rxbuf_mem[wptr_reg] <= rx_byte; // R19

	// alarm channel transmitter: ones, then 0 d0..d5 0, repeated ten times
	logic [15:0] atx_sh_reg;
	logic [4:0]  atx_left_reg;
	logic [3:0]  atx_rep_reg;
	logic        atx_busy_reg;
	wire  [15:0] atx_word = {1'b0, alarm_reg[15:10], 1'b0, 8'hff}; // R1
	wire         atx_end  = atx_left_reg == 5'h01;
	assign ev_atx_done = bit_en_reg && atx_busy_reg && atx_end
		&& atx_rep_reg == `DLK_ALARM_LAST; // R2
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			atx_sh_reg       <= 16'hffff;
			atx_left_reg     <= 5'h00;
			atx_rep_reg      <= 4'h0;
			atx_busy_reg     <= 1'b0;
			alarm_tx_bit_out <= 1'b1;
		end
		else if (bit_en_reg)
		begin
			alarm_tx_bit_out <= atx_busy_reg ? atx_sh_reg[0] : 1'b1;
			if (!atx_busy_reg)
			begin
				atx_busy_reg <= alarm_reg[`DLK_B_ATXEN];
				atx_sh_reg   <= atx_word;
				atx_left_reg <= `DLK_ALARM_LEN;
				atx_rep_reg  <= 4'h0;
			end
			else if (!atx_end)
			begin
				atx_sh_reg   <= atx_sh_reg >> 1;
				atx_left_reg <= atx_left_reg - 5'h01;
			end
			else
			begin
				atx_busy_reg <= !ev_atx_done; // R2
				atx_sh_reg   <= atx_word;
				atx_left_reg <= `DLK_ALARM_LEN;
				atx_rep_reg  <= atx_rep_reg + 4'h1;
			end
		end

	// alarm channel receiver: sliding window matched against the codeword shape
	logic [15:0] arx_win_reg;
	wire  [15:0] arx_nw = {alarm_rx_bit_in, arx_win_reg[15:1]};
	assign ev_arx = bit_en_reg && arx_nw[7:0] == 8'hff && !arx_nw[8] && !arx_nw[15];
	always_ff @(posedge clk_in or posedge rst_in)
		if (rst_in)
		begin
			arx_win_reg  <= 16'hffff;
			arx_data_reg <= 6'h00;
		end
		else if (bit_en_reg)
		begin
			arx_win_reg <= arx_nw;
			if (ev_arx)
				arx_data_reg <= arx_nw[14:9];
		end

	// checks
	a_alarm_word_load: assert property (@(posedge clk_in) disable iff (rst_in) // R1
		$rose(atx_busy_reg) |-> atx_sh_reg[14:9] == $past(alarm_reg[15:10]))
		else $error("alarm word not taken from bits 15..10");
	a_alarm_ten_reps: assert property (@(posedge clk_in) disable iff (rst_in) // R2
		ev_atx_done |-> atx_rep_reg == 4'h9 ##1 atx_done_reg ##1 data_link_irq_pin_out)
		else $error("alarm repeat count or done interrupt wrong");
	a_alarm_rx_gate: assert property (@(posedge clk_in) disable iff (rst_in) // R3
		(arx_flag_reg && alarm_reg[8]) |=> data_link_irq_pin_out)
		else $error("enabled alarm receive did not reach the pin");
	a_err_mask_xor: assert property (@(posedge clk_in) disable iff (rst_in) // R4
		err_field_in.valid |=> err_field_out.valid
		&& err_field_out.data == ($past(err_field_in.data) ^ $past(alarm_reg[7:0])))
		else $error("error pattern not applied");
	a_rx_irq_clear: assert property (@(posedge clk_in) disable iff (rst_in) // R5
		(rd_dlcs && !ev_rx_byte && !ev_rx_end && !ev_abort) |=> !rx_irq_reg)
		else $error("receiver interrupt survived a status read");
	a_tx_irq_clear: assert property (@(posedge clk_in) disable iff (rst_in) // R6
		(wr_dlcs && !ev_tx_svc) |=> !tx_irq_reg)
		else $error("transmitter interrupt survived a write");
	a_rx_ptr_track: assert property (@(posedge clk_in) disable iff (rst_in) // R7
		ev_rx_byte |=> rx_ptr_reg == $past(wptr_reg) && rx_irq_reg)
		else $error("receive pointer not the last slot written");
	a_tx_ones_force: assert property (@(posedge clk_in) disable iff (rst_in) // R12
		(ctrl_reg.dis_tx && bit_en_reg) |=> dl_tx_bit_out)
		else $error("disabled link sent a zero");
	a_abort_seen: assert property (@(posedge clk_in) disable iff (rst_in) // R10
		ev_abort |=> abort_reg && !inframe_reg)
		else $error("abort not flagged");
endmodule // dlk_top

// file: verilog/dlk_cfg.svh
// register offsets, field positions, reset values and link constants of the data link block
`ifndef DLK_CFG_SVH
`define DLK_CFG_SVH
`define DLK_OFS_ALARM  8'h03
`define DLK_OFS_DLCS   8'h60
`define DLK_OFS_ARX    8'h61
`define DLK_OFS_TXBUF  8'h68
`define DLK_OFS_RXBUF  8'h70
`define DLK_ALARM_RST  16'h0000
`define DLK_CTRL_RST   8'h00
`define DLK_B_ATXEN    9
`define DLK_B_ARXIEN   8
`define DLK_ALARM_LAST 4'h9
`define DLK_ALARM_LEN  5'h10
`define DLK_FLAG       8'h7e
`define DLK_ABORT_BYTE 8'hff
`define DLK_CRC_INIT   16'hffff
`define DLK_CRC_POLY   16'h8408
`define DLK_CRC_GOOD   16'hf0b8
`define DLK_STUFF_RUN  3'h5
`define DLK_FLAG_RUN   3'h6
`define DLK_ONES_MAX   3'h7
`endif

// file: verilog/dlk_pkg.sv
// types shared by the data link block
package dlk_pkg;
	// low byte of the data link control and status register
	typedef struct packed {
		logic       rx_irq_en;
		logic       dis_tx;
		logic [2:0] last_ptr;
		logic       abort;
		logic       send_fcs;
		logic       send;
	} dlk_ctrl_t;
	// one byte queued for the serialiser; raw bytes skip zero insertion
	typedef struct packed {
		logic       raw;
		logic [7:0] data;
	} dlk_entry_t;
	// byte of a transmitted field passing the error mask
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} dlk_byte_t;
	typedef enum logic [2:0] {DLK_TX_IDLE, DLK_TX_DATA, DLK_TX_FCS_LO, DLK_TX_FCS_HI,
		DLK_TX_ABORT} dlk_txs_t;
endpackage

// file: test/dlk_far_end.sv
// far-end line terminal model: loops the data link back and sends alarm codewords
`timescale 1ns/100ps
module dlk_far_end #(
	parameter int BIT_DIV = 2
) (
	input  wire logic clk_in,
	input  wire logic dl_line_in,
	output logic      dl_line_out,
	output logic      alarm_line_out
);
	// both lines idle at one before the first edge
	initial
	begin
		dl_line_out = 1'b1;
		alarm_line_out = 1'b1;
	end
	// remote end in loopback: data link echoed one clock later
	always @(posedge clk_in)
		dl_line_out <= dl_line_in;
	// codeword is eight ones, zero, six data bits lsb first, zero; each bit held one bit time
	task automatic send_alarm(input logic [5:0] d);
		logic [15:0] w;
		w = {1'b0, d, 1'b0, 8'hff};
		for (int i = 0; i < 16; i++)
		begin
			@(posedge clk_in);
			alarm_line_out <= w[i];
			repeat (BIT_DIV - 1) @(posedge clk_in);
		end
		@(posedge clk_in);
		alarm_line_out <= 1'b1;
	endtask
endmodule // dlk_far_end

// file: test/tb.sv
// self-checking bench of the data link block with a looped far end
`timescale 1ns/100ps
module tb;
	localparam int BIT_DIV = 2;
	logic               clk_in = 1'b0;
	logic               rst_in = 1'b1;
	logic [7:0]         addr_in = 8'h00;
	logic [15:0]        wr_data_in = 16'h0000;
	logic               wr_in = 1'b0;
	logic               rd_in = 1'b0;
	logic [15:0]        rd_data_out;
	logic               dl_rx_bit_in;
	logic               dl_tx_bit_out;
	logic               alarm_rx_bit_in;
	logic               alarm_tx_bit_out;
	dlk_pkg::dlk_byte_t err_field_in = '0;
	dlk_pkg::dlk_byte_t err_field_out;
	logic               data_link_irq_pin_out;
	int                 n_errors = 0;
	int                 cmp_count = 0;
	int                 seed = 58;
	int                 falls = 0;
	int                 ones;
	logic               count_on = 1'b0;
	logic               last_al = 1'b1;
	logic [15:0]        rv;
	logic [7:0]         pat;
	logic [5:0]         d;
	logic [2:0]         p;
	logic [7:0]         txq[$];

	// 25 MHz clock
	always #20 clk_in = ~clk_in;

	dlk_top #(.BIT_DIV(BIT_DIV), .FIFO_DEPTH(2)) u_dlk_top (
		.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
		.wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out),
		.dl_rx_bit_in(dl_rx_bit_in), .dl_tx_bit_out(dl_tx_bit_out),
		.alarm_rx_bit_in(alarm_rx_bit_in), .alarm_tx_bit_out(alarm_tx_bit_out),
		.err_field_in(err_field_in), .err_field_out(err_field_out),
		.data_link_irq_pin_out(data_link_irq_pin_out));

	dlk_far_end #(.BIT_DIV(BIT_DIV)) u_dlk_far_end (
		.clk_in(clk_in), .dl_line_in(dl_tx_bit_out), .dl_line_out(dl_rx_bit_in),
		.alarm_line_out(alarm_rx_bit_in));

	// counts falling edges of the alarm line while a burst is watched
	always @(posedge clk_in)
	begin
		if (count_on && last_al && alarm_tx_bit_out === 1'b0)
			falls++;
		last_al = alarm_tx_bit_out;
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] v);
		@(posedge clk_in);
		addr_in <= a;
		wr_data_in <= v;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 v = rd_data_out;
	endtask

	// polls until the masked bits read zero, bounded
	task automatic wait_clear(input logic [7:0] a, input logic [15:0] m);
		int k;
		k = 0;
		rv = m;
		while ((rv & m) != 16'h0000 && k < 3000)
		begin
			rd(a, rv);
			k++;
		end
		chk("poll", 16'h0000, rv & m);
	endtask

	// expected falling edges over ten codewords, line idle high before
	function automatic int alarm_falls(input logic [5:0] v);
		logic [15:0] w;
		logic        q;
		int          n;
		w = {1'b0, v, 1'b0, 8'hff};
		q = 1'b1;
		n = 0;
		for (int i = 0; i < 16; i++)
		begin
			if (q && !w[i])
				n++;
			q = w[i];
		end
		return n * 10;
	endfunction

	// fills the tx buffer, models the crc and queues the bytes the far end returns
	task automatic frame(input int n, input logic fcs);
		logic [15:0] crc;
		logic [7:0]  b;
		txq.delete();
		crc = 16'hffff;
		for (int i = 0; i < n; i++)
		begin
			b = (i == 0) ? 8'hff : 8'($random(seed));
			txq.push_back(b);
			wr(8'h68 + 8'(i), {8'h00, b});
			crc = crc ^ {8'h00, b};
			repeat (8) crc = crc[0] ? ((crc >> 1) ^ 16'h8408) : (crc >> 1);
		end
		crc = ~crc;
		txq.push_back(crc[7:0]);
		txq.push_back(crc[15:8]);
		wr(8'h60, {8'h00, 2'b10, 3'(n - 1), 1'b0, fcs, 1'b1});
		wait_clear(8'h60, 16'h0001);
		repeat (300) @(posedge clk_in);
	endtask

	task automatic results;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog well beyond the expected run
	initial
	begin
		#2000000;
		n_errors++;
		results();
	end

	// main sequence
	initial
	begin
		repeat (12) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(8'h03, rv);
		chk("alarm reg reset", 16'h0000, rv);
		rd(8'h60, rv);
		chk("ctrl reset", 16'h0000, {8'h00, rv[7:0]});
		rd(8'h55, rv);
		chk("unmapped", 16'h0000, rv);
		pat = 8'($random(seed));
		wr(8'h03, {8'h00, pat});
		repeat (8)
		begin
			d = 6'($random(seed));
			@(posedge clk_in);
			err_field_in <= {1'b1, d, 2'b01};
			@(posedge clk_in);
			err_field_in <= '0;
			#1 chk("err field", {7'h00, 1'b1, {d, 2'b01} ^ pat}, {7'h00, err_field_out});
		end
		d = 6'($random(seed));
		count_on = 1'b1;
		wr(8'h03, {d, 2'b10, 8'h00});
		wait_clear(8'h03, 16'h0200);
		repeat (60) @(posedge clk_in);
		count_on = 1'b0;
		chk("alarm falls", 16'(alarm_falls(d)), 16'(falls));
		chk("alarm irq pin", 16'h0001, {15'h0, data_link_irq_pin_out});
		rd(8'h61, rv);
		chk("alarm done", 16'h0001, {15'h0, rv[14]});
		wr(8'h03, 16'h0100);
		repeat (4) @(posedge clk_in);
		chk("pin gated", 16'h0000, {15'h0, data_link_irq_pin_out});
		d = 6'($random(seed));
		u_dlk_far_end.send_alarm(d);
		u_dlk_far_end.send_alarm(d);
		repeat (20) @(posedge clk_in);
		chk("alarm rx pin", 16'h0001, {15'h0, data_link_irq_pin_out});
		rd(8'h61, rv);
		chk("alarm rx", {1'b1, 9'h000, d}, {rv[15], 9'h000, rv[5:0]});
		wr(8'h60, 16'hff40);
		rd(8'h60, rv);
		chk("ctrl low byte", 16'h0040, {8'h00, rv[7:0]});
		repeat (8) @(posedge clk_in);
		ones = 0;
		repeat (40) @(posedge clk_in) ones += int'(dl_tx_bit_out === 1'b1);
		chk("forced ones", 16'h0028, 16'(ones));
		chk("rx irq pin gated", 16'h0000, {15'h0, data_link_irq_pin_out});
		wr(8'h60, 16'h0080);
		repeat (100) @(posedge clk_in);
		chk("rx irq pin enabled", 16'h0001, {15'h0, data_link_irq_pin_out});
		frame(6, 1'b1);
		rd(8'h60, rv);
		chk("rx irq", 16'h0001, {15'h0, rv[15]});
		chk("tx irq", 16'h0001, {15'h0, rv[14]});
		chk("flag seen", 16'h0001, {15'h0, rv[10]});
		chk("good fcs", 16'h0000, {15'h0, rv[9]});
		p = rv[13:11];
		for (int i = 0; i < 8; i++)
		begin
			rd(8'h70 + {5'h00, 3'(p + 3'd1 + 3'(i))}, rv);
			chk("rx slot", {8'h00, txq[i]}, rv);
		end
		rd(8'h60, rv);
		chk("rx irq clear", 16'h0000, {15'h0, rv[15]});
		wr(8'h60, 16'h0080);
		rd(8'h60, rv);
		chk("tx irq clear", 16'h0000, {15'h0, rv[14]});
		frame(3, 1'b0);
		rd(8'h60, rv);
		chk("bad fcs", 16'h0001, {15'h0, rv[9]});
		wr(8'h60, 16'h00b9);
		wr(8'h60, 16'h00bd);
		repeat (400) @(posedge clk_in);
		rd(8'h60, rv);
		chk("abort seen", 16'h0001, {15'h0, rv[8]});
		chk("abort done", 16'h0000, {14'h0, rv[2], rv[0]});
		results();
	end
endmodule // tb
